// File: src/pss_pkg.sv
/*
  Constants, field layout and state types for the program sequencer core.
  Assumes one clock domain and an eight-word AHB-Lite register window.
*/
`default_nettype none
package pss_pkg;
   localparam int          PC_W          = 11;
   localparam logic [10:0] PC_RESET      = 11'h7ff;
   localparam logic [10:0] PC_ONE        = 11'h001;
   localparam int          PORT_W        = 4;
   localparam logic [3:0]  DIR_RESET     = 4'hf;
   localparam logic [7:0]  FLAGS_POR     = 8'h18;
   localparam logic [7:0]  FLAGS_UPPER_CLR = 8'h1f;
   localparam logic [7:0]  PTR_RO_ONE    = 8'h80;
   localparam logic [4:0]  IND_PORT_ADDR = 5'h00;
   localparam int          F_C           = 0;
   localparam int          F_HC          = 1;
   localparam int          F_Z           = 2;
   localparam int          F_PD          = 3;
   localparam int          F_TO          = 4;
   localparam int          F_PG_LO       = 5;
   localparam int          F_PG_HI       = 6;
   localparam int          PTR_BANK_LO   = 5;
   localparam int          PTR_BANK_HI   = 6;
   localparam int          ADDR_BIT4     = 4;
   localparam logic [2:0]  IDX_PC        = 3'h0;
   localparam logic [2:0]  IDX_FLAGS     = 3'h1;
   localparam logic [2:0]  IDX_PTR       = 3'h2;
   localparam logic [2:0]  IDX_PORT      = 3'h3;
   localparam logic [2:0]  IDX_DIR       = 3'h4;
   localparam logic [2:0]  IDX_STACK     = 3'h5;
   localparam logic [2:0]  IDX_CTRL      = 3'h6;
   localparam logic [2:0]  IDX_LATCH     = 3'h7;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY    = 2'h0;

   typedef enum logic [2:0] {
      OP_SEQ,
      OP_JUMP,
      OP_CALL,
      OP_RETURN_WITH_LITERAL,
      OP_PCWR
   } pss_op_t;

   typedef struct packed {
      logic [10:0] pc;
      logic [10:0] stk1;
      logic [10:0] stk2;
      logic [7:0]  flags;
      logic [7:0]  ptr;
      logic [3:0]  latch;
      logic [3:0]  dir;
      logic        hold;
      logic [7:0]  wlit;
      logic        wload;
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
      logic        rst_s1;
      logic        rst_s2;
      logic        dp_wr;
      logic [2:0]  dp_idx;
      logic [31:0] rdata;
   } pss_state_t;
endpackage
`default_nettype wire

// File: src/pss_core.sv
/*
  Program counter, return stack, flags word, indirect pointer banking and the
  first I/O port of a small 8-bit controller, with an AHB-Lite register window.
  Assumes the decoder issues one step pulse per executed instruction and that
  the AHB master performs single word transfers.
*/
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Any reset drives counter to all ones.
// - Counter increments after each non-branching instruction.
// - Jump loads nine operand bits plus page.
// - Call pushes return, loads eight bits, page.
// - Counter destination: result low, bit8 cleared.
// - Increment carries across pages, page bits kept.
// - Two-level stack keeps only newest returns.
// - Return pops level 1, loads literal.
// - Return restores full address, page bits untouched.
// - Own flag updates follow writes; expiry/powerdown read-only.
// - Carry is add carry, inverted borrow.
// - Half carry mirrors carry on low nibble.
// - Reset-cause flags change only on listed events.
// - External reset leaves reset-cause flags alone.
// - Expiry and sleep ignore current flag values.
// - Page bits in flags; upper three cleared.
// - Pointer low five bits select indirect target.
// - Pointer bit seven always reads one.
// - Bit four picks common area or bank.
// - Port read returns pin levels always.
// - Reset makes all pins inputs.
// - First port low four bits; rest zero.
// - Indirect access to indirect port reads zero.
// - Counter reset value is address 7ff.
module pss_core
   import pss_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic [1:0]  hresp,
   input  wire logic        external_reset_pin_n,
   input  wire logic        watchdog_expiry,
   input  wire logic        sleep_op,
   input  wire logic        watchdog_clear_op,
   input  wire logic        step,
   input  wire pss_op_t     op_kind,
   input  wire logic [8:0]  operand,
   input  wire logic [7:0]  result,
   input  wire logic [7:0]  literal,
   input  wire logic        flags_we,
   input  wire logic        ptr_we,
   input  wire logic        port_we,
   input  wire logic        direction_load_op,
   input  wire logic [3:0]  direction_data,
   input  wire logic        carry_we,
   input  wire logic        carry_in,
   input  wire logic        half_carry_we,
   input  wire logic        half_carry_in,
   input  wire logic        zero_we,
   input  wire logic        ind_sel,
   input  wire logic [4:0]  file_addr,
   input  wire logic [3:0]  port_pin_in,
   output var  logic [10:0] prog_addr,
   output var  logic [7:0]  flags_word,
   output var  logic [7:0]  indirect_pointer,
   output var  logic [7:0]  first_io_port,
   output var  logic [6:0]  data_addr,
   output var  logic        indirect_null,
   output var  logic [7:0]  wreg_literal,
   output var  logic        wreg_load,
   output var  logic [3:0]  port_out,
   output var  logic [3:0]  port_oe
);
   pss_state_t  st_r;
   pss_state_t  st_nxt;
   logic        dev_rst;
   logic        go;
   logic        ap_take;
   logic [4:0]  eff_addr;
   logic [7:0]  ptr_rd;
   logic [7:0]  port_rd;
   logic [31:0] rd_val;
   logic [7:0]  wr_flags;

   assign dev_rst   = !st_r.rst_s2 || watchdog_expiry;
   assign go        = step && !st_r.hold && !dev_rst;
   assign ap_take   = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign ptr_rd    = st_r.ptr | PTR_RO_ONE;
   assign port_rd   = {4'h0, st_r.pin_s2};
   assign eff_addr  = ind_sel ? st_r.ptr[4:0] : file_addr;
   // Bit four clear selects the shared low block whatever bank is chosen.
   assign data_addr = {eff_addr[ADDR_BIT4] ? st_r.ptr[PTR_BANK_HI:PTR_BANK_LO] : 2'h0,
                       eff_addr};
   assign indirect_null = ind_sel && (st_r.ptr[4:0] == IND_PORT_ADDR);

   assign prog_addr        = st_r.pc;
   assign flags_word       = st_r.flags;
   assign indirect_pointer = ptr_rd;
   assign first_io_port    = port_rd;
   assign wreg_literal     = st_r.wlit;
   assign wreg_load        = st_r.wload;
   assign port_out         = st_r.latch;
   assign port_oe          = ~st_r.dir;
   assign hrdata           = st_r.rdata;
   assign hreadyout        = 1'h1;
   assign hresp            = HRESP_OKAY;

   always_comb begin
      case (haddr[4:2])
         IDX_PC:    rd_val = {21'h0, st_r.pc};
         IDX_FLAGS: rd_val = {24'h0, st_r.flags};
         IDX_PTR:   rd_val = {24'h0, ptr_rd};
         IDX_PORT:  rd_val = {24'h0, port_rd};
         IDX_DIR:   rd_val = {28'h0, st_r.dir};
         IDX_STACK: rd_val = {5'h00, st_r.stk2, 5'h00, st_r.stk1};
         IDX_CTRL:  rd_val = {31'h0, st_r.hold};
         IDX_LATCH: rd_val = {28'h0, st_r.latch};
         default:   rd_val = 32'h0;
      endcase
   end

   always_comb begin
      st_nxt        = st_r;
      wr_flags      = st_r.flags;
      st_nxt.pin_s1 = port_pin_in;
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.rst_s1 = external_reset_pin_n;
      st_nxt.rst_s2 = st_r.rst_s1;
      st_nxt.wload  = 1'h0;
      st_nxt.dp_wr  = ap_take && hwrite;
      st_nxt.dp_idx = haddr[4:2];
      if (ap_take && !hwrite) begin
         st_nxt.rdata = rd_val;
      end
      // Bus writes land first so the decoder's own updates below take priority.
      if (st_r.dp_wr) begin
         case (st_r.dp_idx)
            IDX_FLAGS: wr_flags = hwdata[7:0];
            IDX_PTR:   st_nxt.ptr = hwdata[7:0];
            IDX_DIR:   st_nxt.dir = hwdata[3:0];
            IDX_CTRL:  st_nxt.hold = hwdata[0];
            IDX_LATCH: st_nxt.latch = hwdata[3:0];
            default:   st_nxt.hold = st_r.hold;
         endcase
      end
      if (go) begin
         case (op_kind)
            OP_JUMP: st_nxt.pc = {st_r.flags[F_PG_HI:F_PG_LO], operand};
            OP_CALL: begin
               st_nxt.stk1 = st_r.pc + PC_ONE;
               st_nxt.stk2 = st_r.stk1;
               st_nxt.pc   = {st_r.flags[F_PG_HI:F_PG_LO], 1'h0, operand[7:0]};
            end
            OP_RETURN_WITH_LITERAL: begin
               st_nxt.pc    = st_r.stk1;
               st_nxt.stk1  = st_r.stk2;
               st_nxt.wlit  = literal;
               st_nxt.wload = 1'h1;
            end
            OP_PCWR: st_nxt.pc = {st_r.flags[F_PG_HI:F_PG_LO], 1'h0, result};
            default: st_nxt.pc = st_r.pc + PC_ONE;
         endcase
         if (flags_we) begin
            wr_flags = result;
         end
         if (ptr_we) begin
            st_nxt.ptr = result;
         end
         if (port_we) begin
            st_nxt.latch = result[3:0];
         end
         if (direction_load_op) begin
            st_nxt.dir = direction_data;
         end
      end
      // Expiry and powerdown never take written values.
      wr_flags[F_TO] = st_r.flags[F_TO];
      wr_flags[F_PD] = st_r.flags[F_PD];
      if (go) begin
         if (carry_we) begin
            wr_flags[F_C] = carry_in;
         end
         if (half_carry_we) begin
            wr_flags[F_HC] = half_carry_in;
         end
         if (zero_we) begin
            wr_flags[F_Z] = (result == 8'h00);
         end
         // Flag values are not consulted, so sleep always acts and clear acts unless sleep is set too.
         if (sleep_op) begin
            wr_flags[F_TO] = 1'h1;
            wr_flags[F_PD] = 1'h0;
         end else if (watchdog_clear_op) begin
            wr_flags[F_TO] = 1'h1;
            wr_flags[F_PD] = 1'h1;
         end
      end
      if (watchdog_expiry) begin
         wr_flags[F_TO] = 1'h0;
      end
      st_nxt.flags = wr_flags;
      // The external pin reset touches neither expiry nor powerdown.
      if (dev_rst) begin
         st_nxt.pc    = PC_RESET;
         st_nxt.flags = wr_flags & FLAGS_UPPER_CLR;
         st_nxt.dir   = DIR_RESET;
         st_nxt.wload = 1'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r        <= '0;
         st_r.pc     <= PC_RESET;
         st_r.flags  <= FLAGS_POR;
         st_r.dir    <= DIR_RESET;
         st_r.rst_s1 <= 1'h0;
         st_r.rst_s2 <= 1'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   chk_reset_pc_ones: assert property (@(posedge hclk) disable iff (!hresetn)
      !st_r.rst_s2 |=> (st_r.pc == PC_RESET) && (st_r.flags[F_PG_HI:F_PG_LO] == 2'h0))
      else $error("counter or page not cleared by device reset");

   chk_seq_advance: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_SEQ) |=> st_r.pc == $past(st_r.pc) + PC_ONE)
      else $error("sequential step did not advance counter by one");

   chk_page_carry: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_SEQ) && (st_r.pc[8:0] == 9'h1ff) && !flags_we && !st_r.dp_wr
      |=> (st_r.pc[10:9] == $past(st_r.pc[10:9]) + 2'h1)
          && $stable(st_r.flags[F_PG_HI:F_PG_LO]))
      else $error("page carry wrong or page bits changed");

   chk_jump_load: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_JUMP)
      |=> st_r.pc == {$past(st_r.flags[F_PG_HI:F_PG_LO]), $past(operand)})
      else $error("jump target wrong");

   chk_call_push: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_CALL)
      |=> (st_r.stk1 == $past(st_r.pc) + PC_ONE) && (st_r.stk2 == $past(st_r.stk1))
          && (st_r.pc[8] == 1'h0) && (st_r.pc[7:0] == $past(operand[7:0])))
      else $error("call push or target wrong");

   chk_ret_pop: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_RETURN_WITH_LITERAL)
      |=> (st_r.pc == $past(st_r.stk1)) && (st_r.stk1 == $past(st_r.stk2))
          && (st_r.stk2 == $past(st_r.stk2)) && wreg_load && (wreg_literal == $past(literal)))
      else $error("return did not pop stack or load literal");

   chk_pc_dest: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_PCWR)
      |=> st_r.pc == {$past(st_r.flags[F_PG_HI:F_PG_LO]), 1'h0, $past(result)})
      else $error("counter destination load wrong");

   chk_ret_page: assert property (@(posedge hclk) disable iff (!hresetn)
      go && (op_kind == OP_RETURN_WITH_LITERAL) && !flags_we && !st_r.dp_wr
      |=> $stable(st_r.flags[F_PG_HI:F_PG_LO]))
      else $error("return changed page bits");

   chk_flag_lock: assert property (@(posedge hclk) disable iff (!hresetn)
      !watchdog_expiry && !(go && (sleep_op || watchdog_clear_op))
      |=> $stable(st_r.flags[F_PD:F_PD]) && $stable(st_r.flags[F_TO:F_TO]))
      else $error("reset-cause flags changed without event");

   chk_sleep_flags: assert property (@(posedge hclk) disable iff (!hresetn)
      go && sleep_op && !watchdog_expiry |=> st_r.flags[F_TO] && !st_r.flags[F_PD])
      else $error("sleep did not set expiry and clear powerdown");

   chk_expiry_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      watchdog_expiry |=> !st_r.flags[F_TO] && (st_r.pc == PC_RESET)
                          && (st_r.flags[F_PD] == $past(st_r.flags[F_PD])))
      else $error("expiry handling wrong");

   chk_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      go && zero_we |=> st_r.flags[F_Z] == ($past(result) == 8'h00))
      else $error("zero flag mismatch");

   chk_ptr_bit7: assert property (@(posedge hclk) disable iff (!hresetn)
      indirect_pointer[7] && (indirect_pointer[6:0] == st_r.ptr[6:0])
      && (first_io_port[7:4] == 4'h0))
      else $error("pointer bit 7 or port upper bits wrong");

   chk_ind_null: assert property (@(posedge hclk) disable iff (!hresetn)
      ind_sel && (st_r.ptr[4:0] == IND_PORT_ADDR) |-> indirect_null && (data_addr[4:0] == 5'h00))
      else $error("indirect self access not flagged");

   chk_dir_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      dev_rst |=> port_oe == 4'h0)
      else $error("pins not made inputs on reset");

   chk_stack_deep_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !(go && (op_kind == OP_CALL)) |=> $stable(st_r.stk2))
      else $error("stack level 2 changed without a call");

   chk_stack_top_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !(go && ((op_kind == OP_CALL) || (op_kind == OP_RETURN_WITH_LITERAL))) |=> $stable(st_r.stk1))
      else $error("stack level 1 changed without call or return");

   chk_carry_take: assert property (@(posedge hclk) disable iff (!hresetn)
      go && carry_we |=> st_r.flags[F_C] == $past(carry_in))
      else $error("carry flag did not take its update");

   chk_half_take: assert property (@(posedge hclk) disable iff (!hresetn)
      go && half_carry_we |=> st_r.flags[F_HC] == $past(half_carry_in))
      else $error("half carry flag did not take its update");

   chk_pin_reset_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      !st_r.rst_s2 && !watchdog_expiry
      |=> $stable(st_r.flags[F_TO]) && $stable(st_r.flags[F_PD]))
      else $error("pin reset changed reset-cause flags");

   chk_upper_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      dev_rst |=> (st_r.flags & ~FLAGS_UPPER_CLR) == 8'h00)
      else $error("upper flag bits not cleared by reset");

   chk_pc_all_ones: assert property (@(posedge hclk) disable iff (!hresetn)
      dev_rst |=> prog_addr == {PC_W{1'b1}})
      else $error("counter not at top address after reset");

   chk_clear_flags: assert property (@(posedge hclk) disable iff (!hresetn)
      go && watchdog_clear_op && !sleep_op && !watchdog_expiry
      |=> st_r.flags[F_TO] && st_r.flags[F_PD])
      else $error("watchdog clear did not set both flags");

   chk_pc_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !go && !dev_rst |=> $stable(st_r.pc))
      else $error("counter moved without an executed instruction");

   chk_common_block: assert property (@(posedge hclk) disable iff (!hresetn)
      !data_addr[ADDR_BIT4] |-> (data_addr[PTR_BANK_HI:PTR_BANK_LO] == 2'h0))
      else $error("common block address carries a bank");

   chk_bank_pick: assert property (@(posedge hclk) disable iff (!hresetn)
      data_addr[ADDR_BIT4]
      |-> (data_addr[PTR_BANK_HI:PTR_BANK_LO] == st_r.ptr[PTR_BANK_HI:PTR_BANK_LO]))
      else $error("banked address does not follow pointer bank");

   chk_ind_target: assert property (@(posedge hclk) disable iff (!hresetn)
      ind_sel |-> (data_addr[4:0] == st_r.ptr[4:0]))
      else $error("indirect target not taken from pointer");

   chk_direct_target: assert property (@(posedge hclk) disable iff (!hresetn)
      !ind_sel |-> (data_addr[4:0] == file_addr))
      else $error("direct target not taken from operand");

   chk_port_sync: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) && $past(hresetn, 2)
      |-> (first_io_port == {4'h0, $past(port_pin_in, 2)}))
      else $error("port read does not show pin levels");

   chk_ptr_bus_read: assert property (@(posedge hclk) disable iff (!hresetn)
      ap_take && !hwrite && (haddr[4:2] == IDX_PTR)
      |=> hrdata[7] && (hrdata[31:8] == 24'h0))
      else $error("pointer bus read lost its fixed bit");

   chk_page_write: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.dp_wr && (st_r.dp_idx == IDX_FLAGS) && !go && !dev_rst
      |=> st_r.flags[F_PG_HI:F_PG_LO] == $past(hwdata[F_PG_HI:F_PG_LO]))
      else $error("page bits did not take a bus write");

   chk_dir_load: assert property (@(posedge hclk) disable iff (!hresetn)
      go && direction_load_op |=> port_oe == ~$past(direction_data))
      else $error("direction load did not set drivers");

   chk_wload_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      !(go && (op_kind == OP_RETURN_WITH_LITERAL)) |=> !wreg_load)
      else $error("literal load without a return");
endmodule // pss_core
`default_nettype wire

// File: test/pss_decoder_model.sv
/*
  Partner model of program memory and instruction decode for pss_core.
  Assumes the bench calls exec from one process, between clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module pss_decoder_model
   import pss_pkg::*;
(
   input  wire logic        hclk,
   output var  logic        step,
   output var  pss_op_t     op_kind,
   output var  logic [8:0]  operand,
   output var  logic [7:0]  result,
   output var  logic [10:0] ctl
);
   // Control bits 10 to 0: sleep, clear, direction, port, pointer, flags,
   // zero, half we, half in, carry we, carry in. Literal shares result.
   initial begin
      step = 1'b0;
      op_kind = OP_SEQ;
      operand = 9'h000;
      result = 8'h00;
      ctl = 11'h000;
   end
   // One step pulse per instruction; a pin drives only after a zero load.
   task automatic exec(input pss_op_t k, input logic [8:0] o, input logic [7:0] r,
                       input logic [10:0] c);
      @(posedge hclk);
      step <= 1'b1;
      op_kind <= k;
      operand <= o;
      result <= r;
      ctl <= c;
      @(posedge hclk);
      step <= 1'b0;
      ctl <= 11'h000;
   endtask
endmodule // pss_decoder_model
`default_nettype wire

// File: test/pss_core_tb.sv
/*
  Self-checking bench for pss_core with an AHB-Lite master and decode model.
  Assumes a zero-wait slave and one step pulse per executed instruction.
*/
`timescale 1ns/1ns
`default_nettype none
module pss_core_tb
   import pss_pkg::*;
();
   localparam logic [10:0] K_SLP = 11'h400, K_CLR = 11'h200, K_DIR = 11'h100,
      K_PRT = 11'h080, K_PTR = 11'h040, K_FLG = 11'h020, K_Z = 11'h010,
      K_HW = 11'h008, K_HI = 11'h004, K_CW = 11'h002, K_CI = 11'h001;
   logic        hclk, hreadyout, step, indirect_null, wreg_load;
   logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ind_sel = 1'b0;
   logic        external_reset_pin_n = 1'b1, watchdog_expiry = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [10:0] ctl, prog_addr;
   logic [8:0]  operand;
   logic [7:0]  result, flags_word, indirect_pointer, first_io_port, wreg_literal;
   logic [6:0]  data_addr;
   logic [4:0]  file_addr = 5'h00;
   logic [3:0]  port_pin_in = 4'h0, port_out, port_oe;
   pss_op_t     op_kind;
   int          errors = 0, cmp_count = 0;

   pss_core DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(),
      .external_reset_pin_n, .watchdog_expiry, .sleep_op(ctl[10]),
      .watchdog_clear_op(ctl[9]), .step, .op_kind, .operand, .result,
      .literal(result), .flags_we(ctl[5]), .ptr_we(ctl[6]), .port_we(ctl[7]),
      .direction_load_op(ctl[8]), .direction_data(result[3:0]), .carry_we(ctl[1]),
      .carry_in(ctl[0]), .half_carry_we(ctl[3]), .half_carry_in(ctl[2]),
      .zero_we(ctl[4]), .ind_sel, .file_addr, .port_pin_in, .prog_addr,
      .flags_word, .indirect_pointer, .first_io_port, .data_addr, .indirect_null,
      .wreg_literal, .wreg_load, .port_out, .port_oe);
   pss_decoder_model model (.hclk, .step, .op_kind, .operand, .result, .ctl);

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic results();
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The slave answers at once today, but the wait stays bounded, not fixed.
   task automatic rdy();
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 16) begin
            errors++;
            results();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hrdata;
      #1;
   endtask

   task automatic ex(input pss_op_t k, input logic [8:0] o, input logic [7:0] r,
                     input logic [10:0] c);
      model.exec(k, o, r, c);
      #1;
   endtask

   task automatic t_reset();
      chk(32'(prog_addr), 32'h7ff);
      chk(32'(flags_word), 32'h18);
      chk(32'(port_oe), 32'h0);
      bus(1'b0, 32'h08, 32'h0);
      chk(rd, 32'h80);
   endtask

   task automatic t_jump();
      ex(OP_JUMP, 9'h1ff, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h1ff);
      ex(OP_SEQ, 9'h000, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h200);
      chk(32'(flags_word), 32'h18);
      ex(OP_SEQ, 9'h000, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h201);
   endtask

   task automatic t_call();
      bus(1'b1, 32'h04, 32'h40);
      ex(OP_CALL, 9'h1ab, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h4ab);
      ex(OP_CALL, 9'h033, 8'h00, 11'h000);
      ex(OP_CALL, 9'h0ff, 8'h00, 11'h000);
      bus(1'b0, 32'h14, 32'h0);
      chk(rd, 32'h04ac0434);
      bus(1'b1, 32'h04, 32'h00);
      ex(OP_RETURN_WITH_LITERAL, 9'h000, 8'h5a, 11'h000);
      chk(32'(prog_addr), 32'h434);
      chk(32'({wreg_load, wreg_literal}), 32'h15a);
      ex(OP_RETURN_WITH_LITERAL, 9'h000, 8'h00, 11'h000);
      ex(OP_RETURN_WITH_LITERAL, 9'h000, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h4ac);
      chk(32'(flags_word), 32'h18);
      bus(1'b1, 32'h04, 32'h20);
      ex(OP_PCWR, 9'h000, 8'hcd, 11'h000);
      chk(32'(prog_addr), 32'h2cd);
   endtask

   task automatic t_flags();
      ex(OP_SEQ, 9'h000, 8'h00, K_SLP);
      bus(1'b1, 32'h04, 32'hff);
      chk(32'(flags_word), 32'hf7);
      ex(OP_SEQ, 9'h000, 8'h00, K_FLG | K_Z);
      chk(32'(flags_word), 32'h14);
      ex(OP_SEQ, 9'h000, 8'h01, K_Z | K_CW | K_CI | K_HW | K_HI);
      chk(32'(flags_word), 32'h13);
      ex(OP_SEQ, 9'h000, 8'h01, K_CW | K_HW);
      chk(32'(flags_word), 32'h10);
      ex(OP_SEQ, 9'h000, 8'h00, K_CLR);
      chk(32'(flags_word), 32'h18);
      ex(OP_SEQ, 9'h000, 8'h00, K_SLP);
      bus(1'b1, 32'h04, 32'h60);
      @(posedge hclk);
      external_reset_pin_n <= 1'b0;
      repeat (3) @(posedge hclk);
      external_reset_pin_n <= 1'b1;
      repeat (5) @(posedge hclk);
      #1;
      chk(32'(flags_word), 32'h10);
      for (int n = 0; n < 2; n++) begin
         ex(OP_JUMP, 9'h123, 8'h00, 11'h000);
         @(posedge hclk);
         watchdog_expiry <= 1'b1;
         @(posedge hclk);
         watchdog_expiry <= 1'b0;
         repeat (4) @(posedge hclk);
         #1;
         chk(32'(prog_addr), 32'h7ff);
         chk(32'(flags_word), 32'h00);
      end
   endtask

   task automatic t_ptr_port();
      bus(1'b1, 32'h08, 32'h35);
      @(posedge hclk);
      ind_sel <= 1'b1;
      bus(1'b0, 32'h08, 32'h0);
      chk(rd, 32'hb5);
      chk(32'({indirect_null, data_addr}), 32'h35);
      bus(1'b1, 32'h08, 32'h25);
      chk(32'(data_addr), 32'h05);
      ex(OP_SEQ, 9'h000, 8'h60, K_PTR);
      chk(32'({indirect_null, indirect_pointer}), 32'h1e0);
      @(posedge hclk);
      ind_sel <= 1'b0;
      file_addr <= 5'h13;
      port_pin_in <= 4'ha;
      repeat (4) @(posedge hclk);
      #1;
      chk(32'(data_addr), 32'h73);
      bus(1'b0, 32'h0c, 32'h0);
      chk(rd, 32'h0a);
      ex(OP_SEQ, 9'h000, 8'h05, K_DIR);
      chk(32'(port_oe), 32'ha);
      ex(OP_SEQ, 9'h000, 8'hf6, K_PRT);
      chk(32'({port_out, first_io_port}), 32'h60a);
   endtask

   task automatic t_hold();
      bus(1'b1, 32'h18, 32'h1);
      ex(OP_JUMP, 9'h055, 8'h00, 11'h000);
      bus(1'b0, 32'h00, 32'h0);
      chk(rd, 32'h002);
      bus(1'b1, 32'h18, 32'h0);
      ex(OP_JUMP, 9'h055, 8'h00, 11'h000);
      chk(32'(prog_addr), 32'h055);
      bus(1'b1, 32'h10, 32'h3);
      bus(1'b1, 32'h1c, 32'h9);
      chk(32'({port_out, port_oe}), 32'h9c);
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h3);
   endtask

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
      #1;
      t_reset();
      t_jump();
      t_call();
      t_flags();
      t_ptr_port();
      t_hold();
      results();
   end

   // A hang anywhere ends the run as a mismatch.
   initial begin
      #400000;
      errors++;
      results();
   end
endmodule // pss_core_tb
`default_nettype wire
